/* File: bench/dbgc_host_model.sv */
// host debugger model: sends link bytes and collects response bytes
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module dbgc_host_model
	import dbgc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic resp_valid_ff, // byte from device strobe
	input wire logic [7:0] resp_byte_ff, // byte from device
	output logic cmd_valid, // byte to device strobe
	output logic [7:0] cmd_byte // byte to device
);
	// idle line at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
	end

	// one byte per call; the idle line carries the inverse so a stale
	// byte is never taken for a fresh one
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_byte = b;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		cmd_byte = ~b;
	endtask : send

	// register read answer
	// the answer stands one cycle only, so it is taken right away
	task automatic read(input logic [7:0] op, output logic [7:0] d,
		output logic ok);
		send(op);
		ok = resp_valid_ff;
		d = resp_byte_ff;
	endtask : read

	// control write
	// reserved bits are always sent as zero
	task automatic write_ctl(input logic [7:0] v);
		send(DBGC_CMD_WR_CTL);
		send(v & 8'hF1);
	endtask : write_ctl
endmodule : dbgc_host_model

/* File: bench/dbgc_top_tb_top.sv */
// testbench for the debugger control and status block
// assumes the host model drives the link and this module the cpu side
`timescale 1ns/1ps
module dbgc_top_tb_top
	import dbgc_pkg::*;
;
	logic clk; // system clock
	logic resetn; // debugger reset
	logic cmd_valid; // link strobe
	logic [7:0] cmd_byte; // link byte
	logic brk_decoded; // breakpoint pulse
	logic cpu_halt_state; // low-power halt
	logic rp_option_n; // read protect, 0 on
	logic resp_valid_ff; // answer strobe
	logic [7:0] resp_byte_ff; // answer byte
	logic cpu_stop_ff; // debug mode
	logic brk_nop_ff; // breakpoint as nop
	logic brk_spin_ff; // breakpoint spin
	logic sys_reset_ff; // device reset
	logic [7:0] rd; // read data
	logic ok; // answer seen
	int miscompares = 0; // mismatch count
	int checks_done = 0; // comparison count

	dbgc_top u_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .brk_decoded(brk_decoded),
		.cpu_halt_state(cpu_halt_state), .rp_option_n(rp_option_n),
		.resp_valid_ff(resp_valid_ff), .resp_byte_ff(resp_byte_ff),
		.cpu_stop_ff(cpu_stop_ff), .brk_nop_ff(brk_nop_ff),
		.brk_spin_ff(brk_spin_ff), .sys_reset_ff(sys_reset_ff));

	dbgc_host_model u_host (.clk(clk), .resp_valid_ff(resp_valid_ff),
		.resp_byte_ff(resp_byte_ff), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte));

	// 250 MHz clock
	always #2 clk = ~clk;

	// ----------------------------------------------------------------
	// compare and helper tasks
	// ----------------------------------------------------------------
	task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk_byte

	task automatic chk_bit(string nm, logic e, logic g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic chk_int(string nm, int e, int g);
		checks_done++;
		if (g != e)
		begin
			miscompares++;
			$display("mismatch %s exp %0d got %0d", nm, e, g);
		end
	endtask : chk_int

	// read one register and compare the answer
	task automatic rd_chk(logic [7:0] op, logic [7:0] e, string nm);
		u_host.read(op, rd, ok);
		chk_bit("resp valid", 1'b1, ok);
		chk_byte(nm, e, rd);
	endtask : rd_chk

	// one-cycle breakpoint decode; returns just after the edge that takes it
	task automatic brk_pulse();
		@(posedge clk);
		#1;
		brk_decoded = 1'b1;
		@(posedge clk);
		#1;
		brk_decoded = 1'b0;
	endtask : brk_pulse

	// cpu-side levels, set at time zero or changed just after a clock edge
	task automatic set_pins(input logic halt, input logic prot_n);
		cpu_halt_state = halt;
		rp_option_n = prot_n;
	endtask : set_pins

	// waits for the device reset and measures how long it is held
	task automatic seq_chk();
		int n;
		n = 0;
		while (sys_reset_ff !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (sys_reset_ff === 1'b1 && n < 1000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_int("reset length", DBGC_POR_CYC, n);
	endtask : seq_chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		brk_decoded = 1'b0;
		set_pins(1'b0, 1'b1);
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk_bit("nop", 1'b1, brk_nop_ff);
		rd_chk(DBGC_CMD_RD_CTL, DBGC_CTL_RESET, "ctl reset");
		brk_pulse();
		chk_bit("stop", 1'b0, cpu_stop_ff);
		rd_chk(DBGC_CMD_RD_STAT, 8'h00, "stat");
		set_pins(1'b1, 1'b1);
		rd_chk(DBGC_CMD_RD_STAT, 8'h40, "stat halt");
		set_pins(1'b0, 1'b0);
		rd_chk(DBGC_CMD_RD_STAT, 8'h20, "stat prot");
		set_pins(1'b0, 1'b1);
		// reset and stop
		u_host.write_ctl(DBGC_VAL_STOP);
		chk_bit("stop", 1'b1, cpu_stop_ff);
		seq_chk();
		rd_chk(DBGC_CMD_RD_CTL, 8'h80, "ctl stop");
		u_host.write_ctl(DBGC_VAL_RUN);
		chk_bit("stop", 1'b0, cpu_stop_ff);
		chk_bit("nop", 1'b0, brk_nop_ff);
		// reserved bits sent as ones on purpose
		u_host.send(DBGC_CMD_WR_CTL);
		u_host.send(8'h4E);
		rd_chk(DBGC_CMD_RD_CTL, 8'h40, "ctl rsvd");
		// breakpoint into debug mode with acknowledge
		u_host.write_ctl(8'h60);
		brk_pulse();
		chk_bit("stop", 1'b1, cpu_stop_ff);
		@(posedge clk);
		#1;
		chk_bit("ack valid", 1'b1, resp_valid_ff);
		chk_byte("ack byte", DBGC_ACK_BYTE, resp_byte_ff);
		rd_chk(DBGC_CMD_RD_STAT, 8'h80, "stat dbg");
		// spin on breakpoint, idle stays sticky until a write
		u_host.write_ctl(8'h50);
		chk_bit("spin", 1'b1, brk_spin_ff);
		brk_pulse();
		chk_bit("stop", 1'b0, cpu_stop_ff);
		rd_chk(DBGC_CMD_RD_STAT, 8'h80, "stat sticky");
		u_host.write_ctl(8'h50);
		rd_chk(DBGC_CMD_RD_STAT, 8'h00, "stat clr");
		// protection blocks leaving debug mode until reset
		set_pins(1'b0, 1'b0);
		u_host.write_ctl(8'h80);
		u_host.write_ctl(8'h00);
		chk_bit("stop", 1'b1, cpu_stop_ff);
		rd_chk(DBGC_CMD_RD_STAT, 8'hA0, "stat prot");
		@(posedge clk);
		#1;
		resetn = 1'b0;
		@(posedge clk);
		#1;
		resetn = 1'b1;
		set_pins(1'b0, 1'b1);
		chk_bit("stop", 1'b0, cpu_stop_ff);
		// reset and go
		u_host.write_ctl(DBGC_VAL_GO);
		seq_chk();
		chk_bit("stop", 1'b0, cpu_stop_ff);
		rd_chk(DBGC_CMD_RD_CTL, 8'h40, "ctl go");
		wrap_up();
	end

	// watchdog well beyond the expected run length
	initial
	begin
		#(4 * 20000);
		miscompares++;
		wrap_up();
	end
endmodule : dbgc_top_tb_top

/* File: logic/dbgc_pkg.sv */
// constants shared by the debugger control and status logic
// assumes a 250 MHz system clock and byte-wide debug link commands
package dbgc_pkg;

	// ----------------------------------------------------------------
	// link command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] DBGC_CMD_RD_STAT = 8'h02; // read status
	localparam logic [7:0] DBGC_CMD_WR_CTL = 8'h04; // write control
	localparam logic [7:0] DBGC_CMD_RD_CTL = 8'h05; // read control
	localparam logic [7:0] DBGC_ACK_BYTE = 8'hFF; // breakpoint ack
	localparam logic [7:0] DBGC_BRK_OPCODE = 8'h00; // breakpoint_opcode

	// ----------------------------------------------------------------
	// control register fields and handy values
	// ----------------------------------------------------------------
	localparam int DBGC_CTL_DBG = 7; // debug_state_bit
	localparam int DBGC_CTL_BREAKPOINT_ENABLE_BIT = 6; // breakpoint_enable_bit
	localparam int DBGC_CTL_ACK = 5; // host_ack_enable_bit
	localparam int DBGC_CTL_SPIN = 4; // breakpoint_spin_select
	localparam int DBGC_CTL_RST = 0; // reset request
	localparam logic [7:0] DBGC_CTL_MASK = 8'hF1; // writable bits
	localparam logic [7:0] DBGC_CTL_RESET = 8'h00; // control reset
	localparam logic [7:0] DBGC_VAL_STOP = 8'h81; // reset and stop
	localparam logic [7:0] DBGC_VAL_GO = 8'h41; // reset and go
	localparam logic [7:0] DBGC_VAL_RUN = 8'h40; // run

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int DBGC_STAT_IDLE = 7; // cpu idle
	localparam int DBGC_STAT_HALT = 6; // low-power halt
	localparam int DBGC_STAT_RP = 5; // read_protection_active_flag

	// ----------------------------------------------------------------
	// device reset sequence length
	// ----------------------------------------------------------------
	localparam int DBGC_CLK_MHZ = 250; // system clock rate
	localparam int DBGC_POR_NS = 1000; // reset sequence time, ns
	localparam int DBGC_POR_CYC = (DBGC_POR_NS * DBGC_CLK_MHZ) / 1000;
	localparam int DBGC_CNT_W = 9; // sequence counter width

	// command decoder states
	typedef enum logic {DBGC_IDLE, DBGC_WDATA} dbgc_state_e;

endpackage : dbgc_pkg

/* File: logic/dbgc_rst_seq.sv */
// device reset sequencer: holds the system reset for the power-on time
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module dbgc_rst_seq
	import dbgc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic resetn, // debugger reset, async low
	input wire logic start, // begin a reset sequence
	output logic busy_ff, // system reset asserted
	output logic done_ff // pulse when sequence ends
);

	// ----------------------------------------------------------------
	// sequence counter
	// ----------------------------------------------------------------
	localparam logic [DBGC_CNT_W-1:0] LAST =
		DBGC_CNT_W'(DBGC_POR_CYC - 1);
	logic [DBGC_CNT_W-1:0] cnt_ff; // cycles into the sequence
	logic [DBGC_CNT_W-1:0] nxt_cnt;
	logic nxt_busy;
	logic nxt_done;

	// next state: a start during a sequence is ignored, it is already
	// resetting the device
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (busy_ff)
		begin
			// end of the power-on time
			if (cnt_ff == LAST)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_cnt = '0;
			end
			else
				nxt_cnt = cnt_ff + 1'b1;
		end
		else if (start)
		begin
			nxt_busy = 1'b1;
			nxt_cnt = '0;
		end
	end

	// registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

endmodule : dbgc_rst_seq

/* File: logic/dbgc_top.sv */
// debugger control and status registers with link command decoding
// assumes the link layer delivers whole bytes on the system clock and
// that cpu-side flags come from logic on the same clock
`timescale 1ns/1ps
module dbgc_top
	import dbgc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic resetn, // debugger reset, async low
	input wire logic cmd_valid, // link byte strobe
	input wire logic [7:0] cmd_byte, // link byte from host
	input wire logic brk_decoded, // cpu decoded breakpoint
	input wire logic cpu_halt_state, // cpu in low-power halt
	input wire logic rp_option_n, // read protect option, 0 on
	output logic resp_valid_ff, // byte to host strobe
	output logic [7:0] resp_byte_ff, // byte to host
	output logic cpu_stop_ff, // stop fetching
	output logic brk_nop_ff, // treat breakpoint as nop
	output logic brk_spin_ff, // re-execute breakpoint
	output logic sys_reset_ff // device reset, high active
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// apply a host write, keeping reserved bits zero and the debug bit
	// set when protection forbids clearing it
	function automatic logic [7:0] ctl_apply(input logic [7:0] old,
		input logic [7:0] data, input logic prot);
		logic [7:0] v;
		v = data & DBGC_CTL_MASK;
		if (prot && old[DBGC_CTL_DBG])
			v[DBGC_CTL_DBG] = 1'b1;
		return v;
	endfunction : ctl_apply

	logic protect; // read protection in force
	assign protect = !rp_option_n;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	dbgc_state_e state_ff; // waiting for opcode or data
	dbgc_state_e nxt_state;
	logic ctl_wr; // control data byte taken
	logic rd_stat; // status read taken
	logic rd_ctl; // control read taken

	// the decoder only tracks the commands this block owns; any other
	// opcode is left to the rest of the debugger
	always_comb
	begin
		nxt_state = state_ff;
		ctl_wr = 1'b0;
		rd_stat = 1'b0;
		rd_ctl = 1'b0;
		case (state_ff)
			DBGC_IDLE:
				if (cmd_valid)
				begin
					if (cmd_byte == DBGC_CMD_RD_STAT)
						rd_stat = 1'b1;
					else if (cmd_byte == DBGC_CMD_RD_CTL)
						rd_ctl = 1'b1;
					else if (cmd_byte == DBGC_CMD_WR_CTL)
						nxt_state = DBGC_WDATA;
				end
			DBGC_WDATA:
				if (cmd_valid)
				begin
					ctl_wr = 1'b1;
					nxt_state = DBGC_IDLE;
				end
			default:
				nxt_state = DBGC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			state_ff <= DBGC_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------------------------------
	// control register and breakpoint handling
	// ----------------------------------------------------------------
	logic [7:0] ctl_ff; // control register
	logic [7:0] nxt_ctl;
	logic brk_seen_ff; // breakpoint since last control write
	logic nxt_brk_seen;
	logic brk_taken; // enabled breakpoint this cycle
	logic seq_done; // reset sequence finished
	logic seq_start; // start a device reset

	assign brk_taken = brk_decoded && ctl_ff[DBGC_CTL_BREAKPOINT_ENABLE_BIT];

	// host write first, hardware events after it so a breakpoint or a
	// finished reset landing in the same cycle is never lost
	always_comb
	begin
		nxt_ctl = ctl_ff;
		nxt_brk_seen = brk_seen_ff;
		seq_start = 1'b0;
		if (ctl_wr)
		begin
			nxt_ctl = ctl_apply(ctl_ff, cmd_byte, protect);
			nxt_brk_seen = 1'b0;
			seq_start = cmd_byte[DBGC_CTL_RST];
		end
		if (brk_taken && !ctl_ff[DBGC_CTL_SPIN])
			nxt_ctl[DBGC_CTL_DBG] = 1'b1;
		if (brk_taken)
			nxt_brk_seen = 1'b1;
		// reset request self-clears; a new request in the
		// same cycle wins, since it starts a fresh sequence
		if (seq_done && !seq_start)
			nxt_ctl[DBGC_CTL_RST] = 1'b0;
	end

	// the debugger keeps its state through the device reset it starts,
	// so a stop request still holds the cpu once that reset ends
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_ff <= DBGC_CTL_RESET;
			brk_seen_ff <= 1'b0;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
			brk_seen_ff <= nxt_brk_seen;
		end
	end

	// ----------------------------------------------------------------
	// cpu-side controls
	// ----------------------------------------------------------------
	logic nxt_stop;
	logic nxt_nop;
	logic nxt_spin;

	always_comb
	begin
		nxt_stop = nxt_ctl[DBGC_CTL_DBG];
		nxt_nop = !nxt_ctl[DBGC_CTL_BREAKPOINT_ENABLE_BIT];
		nxt_spin = nxt_ctl[DBGC_CTL_BREAKPOINT_ENABLE_BIT] && nxt_ctl[DBGC_CTL_SPIN];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cpu_stop_ff <= 1'b0;
			brk_nop_ff <= 1'b1;
			brk_spin_ff <= 1'b0;
		end
		else
		begin
			cpu_stop_ff <= nxt_stop;
			brk_nop_ff <= nxt_nop;
			brk_spin_ff <= nxt_spin;
		end
	end

	// ----------------------------------------------------------------
	// device reset sequencer
	// ----------------------------------------------------------------
	// debugger stays out of reset
	dbgc_rst_seq u_seq (
		.clk(clk),
		.resetn(resetn),
		.start(seq_start),
		.busy_ff(sys_reset_ff),
		.done_ff(seq_done)
	);

	// ----------------------------------------------------------------
	// responses to the host
	// ----------------------------------------------------------------
	logic [7:0] stat; // live status byte
	logic ack_pend_ff; // ack byte waiting for the link
	logic nxt_ack_pend;
	logic nxt_rvalid;
	logic [7:0] nxt_rbyte;

	// read answers take the slot; an ack waits a cycle behind them
	always_comb
	begin
		stat = 8'h00;
		// idle when stopped or after breakpoint
		stat[DBGC_STAT_IDLE] = ctl_ff[DBGC_CTL_DBG] || brk_seen_ff;
		stat[DBGC_STAT_HALT] = cpu_halt_state;
		stat[DBGC_STAT_RP] = protect;
		nxt_ack_pend = ack_pend_ff;
		nxt_rvalid = 1'b0;
		nxt_rbyte = 8'h00;
		if (brk_taken && ctl_ff[DBGC_CTL_ACK])
			nxt_ack_pend = 1'b1;
		if (rd_stat)
		begin
			nxt_rvalid = 1'b1;
			nxt_rbyte = stat;
		end
		else if (rd_ctl)
		begin
			nxt_rvalid = 1'b1;
			nxt_rbyte = ctl_ff;
		end
		else if (ack_pend_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rbyte = DBGC_ACK_BYTE;
			nxt_ack_pend = brk_taken && ctl_ff[DBGC_CTL_ACK];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_pend_ff <= 1'b0;
			resp_valid_ff <= 1'b0;
			resp_byte_ff <= 8'h00;
		end
		else
		begin
			ack_pend_ff <= nxt_ack_pend;
			resp_valid_ff <= nxt_rvalid;
			resp_byte_ff <= nxt_rbyte;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	localparam int SEQ_MAX = 260;

	chk_stop_reset: assert property (
		ctl_wr && cmd_byte == DBGC_VAL_STOP |=> cpu_stop_ff ##1
		sys_reset_ff && cpu_stop_ff)
		else $error("81h did not reset and stop");
	chk_go_reset: assert property (
		ctl_wr && cmd_byte == DBGC_VAL_GO && !protect && !brk_decoded
		|=> !cpu_stop_ff && !brk_nop_ff && ctl_ff[DBGC_CTL_RST])
		else $error("41h did not reset and go");
	chk_run_resume: assert property (
		ctl_wr && cmd_byte == DBGC_VAL_RUN && !protect && !brk_decoded
		|=> !cpu_stop_ff && !brk_nop_ff)
		else $error("40h did not resume");
	chk_brk_debug: assert property (
		brk_taken && !ctl_ff[DBGC_CTL_SPIN] |=> cpu_stop_ff)
		else $error("breakpoint did not enter debug mode");
	chk_protect_hold: assert property (
		protect && ctl_ff[DBGC_CTL_DBG] |=> ctl_ff[DBGC_CTL_DBG])
		else $error("protected debug mode was cleared");
	chk_brk_nop: assert property (
		brk_decoded && !ctl_ff[DBGC_CTL_BREAKPOINT_ENABLE_BIT] && !ctl_wr && !seq_done
		|=> $stable(ctl_ff) && brk_nop_ff)
		else $error("disabled breakpoint changed state");
	chk_ack_sent: assert property (
		brk_taken && ctl_ff[DBGC_CTL_ACK] && !ack_pend_ff
		|-> ##[1:3] resp_valid_ff && resp_byte_ff == DBGC_ACK_BYTE)
		else $error("breakpoint ack not sent");
	chk_rst_clear: assert property (
		$rose(ctl_ff[DBGC_CTL_RST])
		|-> ##[1:SEQ_MAX] !ctl_ff[DBGC_CTL_RST])
		else $error("reset request did not clear");
	chk_idle_flag: assert property (
		brk_taken && !ctl_wr |=> stat[DBGC_STAT_IDLE])
		else $error("idle not shown after breakpoint");
	chk_ctl_rsvd: assert property (
		rd_ctl |=> resp_valid_ff && resp_byte_ff[3:1] == 3'b000)
		else $error("reserved control bits not zero");
	cov_stop: cover property (ctl_wr && cmd_byte == DBGC_VAL_STOP);
	cov_spin: cover property (brk_taken && ctl_ff[DBGC_CTL_SPIN]);
	cov_ack: cover property (resp_valid_ff && resp_byte_ff == DBGC_ACK_BYTE);

endmodule : dbgc_top
